//--- cpu_core_regs.vh
// Purpose: Shared constants of the CPU register set: offsets, fields, resets, codes
// Assumes: Included by its bare name from the design files
// Notes:   Definitions only
`ifndef CPU_CORE_REGS_VH
`define CPU_CORE_REGS_VH

// Register word offsets on the register bus
`define OFS_ACC        8'h00
`define OFS_INDEX      8'h04
`define OFS_STACK      8'h08
`define OFS_IP         8'h0c
`define OFS_FLAGS      8'h10
`define OFS_STATUS     8'h14

// Flag register bit positions
`define FLG_V          7
`define FLG_ONE6       6
`define FLG_ONE5       5
`define FLG_H          4
`define FLG_I          3
`define FLG_N          2
`define FLG_Z          1
`define FLG_C          0

// Reset values
`define SP_RESET       16'h00ff
`define SP_LOW_RESET   8'hff
`define VEC_RESET      16'hfffe
`define ACC_RESET      8'h00
`define INDEX_RESET    16'h0000
`define IP_RESET       16'h0000

// Sequencer operation codes
`define OP_NOP         4'h0
`define OP_ALU         4'h1
`define OP_LDX         4'h2
`define OP_FETCH       4'h3
`define OP_JUMP        4'h4
`define OP_RSP         4'h5
`define OP_CLI         4'h6
`define OP_SEI         4'h7
`define OP_PUSH_INDEX_HIGH_OP        4'h8
`define OP_PULL_INDEX_HIGH_OP        4'h9
`define OP_RTI         4'ha
`define OP_ADDR        4'hb
`define OP_BRANCH      4'hc
`define OP_LDSP        4'hd

// Arithmetic sub-operations
`define ALU_ADD        3'h0
`define ALU_ADC        3'h1
`define ALU_SUB        3'h2
`define ALU_SBC        3'h3
`define ALU_AND        3'h4
`define ALU_LOAD       3'h5
`define ALU_LSL        3'h6
`define ALU_DAA        3'h7

// Signed branch conditions
`define BR_GT          2'h0
`define BR_GE          2'h1
`define BR_LE          2'h2
`define BR_LT          2'h3

// Stacked byte counts
`define IRQ_STACK_BYTES 3'h5
`define ONE_STACK_BYTE  3'h1

// Bus responses
`define RESP_OKAY      2'b00
`define RESP_DECERR    2'b11

`endif

//--- flag_update.v
// Purpose: Arithmetic result and condition flags for one accumulator operation
// Assumes: Purely combinational, used by the register set
// Notes:   upd_* say which of V, H and C the operation changes; N and Z always change
`timescale 1ns/1ps
`include "cpu_core_regs.vh"
module flag_update (
	// Operation
	input  wire [2:0] op,
	input  wire [7:0] a,
	input  wire [7:0] m,
	input  wire       cin,
	input  wire       hin,
	// Result
	output reg  [7:0] result,
	output reg        v,
	output reg        h,
	output wire       n,
	output wire       z,
	output reg        c,
	output reg        upd_v,
	output reg        upd_h,
	output reg        upd_c
);
	reg [8:0] wide;
	reg [4:0] low;
	reg       cy;
	reg [7:0] corr;

	always @* begin
		wide   = 9'h000;
		low    = 5'h00;
		cy     = (op == `ALU_ADC || op == `ALU_SBC) ? cin : 1'b0;
		corr   = 8'h00;
		result = 8'h00;
		v      = 1'b0;
		h      = hin;
		c      = cin;
		upd_v  = 1'b0;
		upd_h  = 1'b0;
		upd_c  = 1'b0;
		case (op)
			`ALU_ADD, `ALU_ADC: begin
				wide   = {1'b0, a} + {1'b0, m} + {8'h00, cy};
				low    = {1'b0, a[3:0]} + {1'b0, m[3:0]} + {4'h0, cy};
				result = wide[7:0];
				h      = low[4];
				c      = wide[8];
				v      = (a[7] & m[7] & ~result[7]) | (~a[7] & ~m[7] & result[7]);
				upd_v  = 1'b1;
				upd_h  = 1'b1;
				upd_c  = 1'b1;
			end
			`ALU_SUB, `ALU_SBC: begin
				wide   = {1'b0, a} - {1'b0, m} - {8'h00, cy};
				result = wide[7:0];
				c      = wide[8];
				v      = (a[7] & ~m[7] & ~result[7]) | (~a[7] & m[7] & result[7]);
				upd_v  = 1'b1;
				upd_c  = 1'b1;
			end
			`ALU_AND: begin
				result = a & m;
				upd_v  = 1'b1;
			end
			`ALU_LOAD: begin
				result = m;
				upd_v  = 1'b1;
			end
			`ALU_LSL: begin
				result = {a[6:0], 1'b0};
				c      = a[7];
				v      = a[7] ^ a[6];
				upd_v  = 1'b1;
				upd_c  = 1'b1;
			end
			default: begin
				// Decimal adjust picks its correction from H, C and the digits
				if (hin || a[3:0] > 4'h9)
					corr[3:0] = 4'h6;
				if (cin || a > 8'h99 || (a[7:4] > 4'h8 && a[3:0] > 4'h9))
					corr[7:4] = 4'h6;
				result = a + corr;
				c      = cin | (corr[7:4] != 4'h0);
				upd_c  = 1'b1;
			end
		endcase
	end

	assign n = result[7];
	assign z = (result == 8'h00);
endmodule

//--- cpu_register_set_flags.v
// Purpose: Programmer-visible CPU registers, flag logic, stacking and vector loads
// Assumes: Sequencer, interrupt sources and memory share CLOCK; memory reads are combinational
// Notes:   Registers are also reachable over AXI4-Lite for software and debug
// Behaviour
// - Accumulator is 8 bits, holds operands and takes arithmetic and logic results.
// - Index pair is high and low bytes forming a 16-bit address or data.
// - Reset sets the stack pointer to 00ff.
// - Stack low byte reset op forces low byte ff, high byte kept.
// - Stack pointer names next free location; push decrements, pull increments.
// - Stack-relative operand address is stack pointer plus 8-bit or 16-bit offset.
// - Instruction pointer steps on each fetch; jumps and interrupts load new address.
// - Reset loads instruction pointer from fffe high and ffff low.
// - Flag register bits 6 and 5 always read one.
// - Overflow flag follows signed overflow; signed branches test it.
// - Half carry is the carry from bit 3 into 4 on adds.
// - Decimal adjust chooses correction from half carry and carry.
// - Mask set blocks maskable interrupts; mask clear accepts them.
// - Interrupt entry stacks registers, then sets mask, then fetches vector.
// - Interrupt entry never stacks index high byte; dedicated ops do.
// - With mask clear, highest-priority pending request is serviced first.
// - Return from interrupt pulls registers and flags, restoring the mask.
// - Reset sets the mask; only the mask clear op and a return from interrupt clear it.
// - Negative flag copies result bit 7.
// - Zero flag set for a zero result, cleared otherwise.
// - Carry takes add carry, subtract borrow, and shift updates.
`timescale 1ns/1ps
`include "cpu_core_regs.vh"
module cpu_register_set_flags #(
	parameter IRQ_LINES = 4,
	parameter IRQ_ID_W  = 2
) (
	// Clock and reset
	input  wire                 CLOCK,
	input  wire                 RSTN,
	// AXI4-Lite write
	input  wire                 AWVALID,
	output wire                 AWREADY,
	input  wire [7:0]           AWADDR,
	input  wire                 WVALID,
	output wire                 WREADY,
	input  wire [31:0]          WDATA,
	input  wire [3:0]           WSTRB,
	output reg                  BVALID,
	input  wire                 BREADY,
	output reg  [1:0]           BRESP,
	// AXI4-Lite read
	input  wire                 ARVALID,
	output wire                 ARREADY,
	input  wire [7:0]           ARADDR,
	output reg                  RVALID,
	input  wire                 RREADY,
	output reg  [31:0]          RDATA,
	output reg  [1:0]           RRESP,
	// Sequencer operations
	input  wire                 OP_VALID,
	output wire                 OP_READY,
	input  wire [3:0]           OP_CODE,
	input  wire [2:0]           OP_SEL,
	input  wire [7:0]           OP_DATA,
	input  wire [15:0]          OP_WIDE,
	output reg  [15:0]          OP_ADDR,
	output reg                  BRANCH_TAKEN,
	output wire                 BUSY,
	output wire [7:0]           FLAGS,
	// Interrupts
	input  wire [IRQ_LINES-1:0] IRQ_REQ,
	input  wire                 BOUNDARY,
	output reg                  IRQ_ACK,
	output reg  [IRQ_ID_W-1:0]  IRQ_ACK_ID,
	// Memory
	output reg  [15:0]          MEM_ADDR,
	output reg                  MEM_RE,
	output reg                  MEM_WE,
	output reg  [7:0]           MEM_WDATA,
	input  wire [7:0]           MEM_RDATA
);
	localparam [1:0] ST_RUN  = 2'd0;
	localparam [1:0] ST_VEC  = 2'd1;
	localparam [1:0] ST_PUSH = 2'd2;
	localparam [1:0] ST_PULL = 2'd3;

	reg [7:0]          acc;
	reg [7:0]          idx_hi;
	reg [7:0]          idx_lo;
	reg [15:0]         sp;
	reg [15:0]         ip;
	reg                flag_v;
	reg                flag_h;
	reg                flag_i;
	reg                flag_n;
	reg                flag_z;
	reg                flag_c;
	reg [1:0]          state;
	reg [2:0]          step;
	reg                one_byte;
	reg [15:0]         vec_addr;
	reg                aw_held;
	reg                w_held;
	reg [7:0]          wr_addr;
	reg [31:0]         wr_data;
	reg [3:0]          wr_strb;
	reg [7:0]          flags_byte;
	reg [IRQ_ID_W-1:0] irq_id;
	integer            k;

	wire [7:0] alu_result;
	wire       alu_v;
	wire       alu_h;
	wire       alu_n;
	wire       alu_z;
	wire       alu_c;
	wire       upd_v;
	wire       upd_h;
	wire       upd_c;
	wire [2:0] stack_count;
	wire       irq_start;
	wire       op_go;
	wire       wr_allow;
	wire       wr_commit;
	wire       signed_lt;
	wire [15:0] addr_base;
	wire [15:0] irq_vec;

	function mapped;
		input [7:0] a;
		begin
			mapped = (a == `OFS_ACC) || (a == `OFS_INDEX) || (a == `OFS_STACK) ||
			         (a == `OFS_IP) || (a == `OFS_FLAGS) || (a == `OFS_STATUS);
		end
	endfunction

	function [15:0] merge16;
		input [15:0] old;
		input [15:0] d;
		input [1:0]  strb;
		begin
			merge16 = {strb[1] ? d[15:8] : old[15:8], strb[0] ? d[7:0] : old[7:0]};
		end
	endfunction

	flag_update u_flag_update (
		.op     (OP_SEL),
		.a      (acc),
		.m      (OP_DATA),
		.cin    (flag_c),
		.hin    (flag_h),
		.result (alu_result),
		.v      (alu_v),
		.h      (alu_h),
		.n      (alu_n),
		.z      (alu_z),
		.c      (alu_c),
		.upd_v  (upd_v),
		.upd_h  (upd_h),
		.upd_c  (upd_c)
	);

	always @* begin
		flags_byte            = 8'h00;
		flags_byte[`FLG_V]    = flag_v;
		flags_byte[`FLG_ONE6] = 1'b1;
		flags_byte[`FLG_ONE5] = 1'b1;
		flags_byte[`FLG_H]    = flag_h;
		flags_byte[`FLG_I]    = flag_i;
		flags_byte[`FLG_N]    = flag_n;
		flags_byte[`FLG_Z]    = flag_z;
		flags_byte[`FLG_C]    = flag_c;
	end

	// Lowest request index has the highest priority
	always @* begin
		irq_id = {IRQ_ID_W{1'b0}};
		for (k = IRQ_LINES - 1; k >= 0; k = k - 1)
			if (IRQ_REQ[k])
				irq_id = k[IRQ_ID_W-1:0];
	end

	assign irq_vec     = `VEC_RESET - {{(15-IRQ_ID_W){1'b0}}, irq_id, 1'b0} - 16'h0002;
	assign FLAGS       = flags_byte;
	assign BUSY        = (state != ST_RUN);
	assign irq_start   = (state == ST_RUN) && BOUNDARY && !flag_i && (|IRQ_REQ);
	assign OP_READY    = (state == ST_RUN) && !irq_start;
	assign op_go       = OP_VALID && OP_READY;
	assign wr_allow    = (state == ST_RUN) && !OP_VALID && !irq_start;
	assign wr_commit   = aw_held && w_held && !BVALID && wr_allow;
	assign stack_count = one_byte ? `ONE_STACK_BYTE : `IRQ_STACK_BYTES;
	assign signed_lt   = flag_n ^ flag_v;
	assign addr_base   = OP_SEL[1] ? {idx_hi, idx_lo} : sp;
	assign AWREADY     = !aw_held;
	assign WREADY      = !w_held;
	assign ARREADY     = !RVALID;

	always @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			acc          <= `ACC_RESET;
			{idx_hi, idx_lo} <= `INDEX_RESET;
			sp           <= `SP_RESET;
			ip           <= `IP_RESET;
			flag_v       <= 1'b0;
			flag_h       <= 1'b0;
			flag_i       <= 1'b1;
			flag_n       <= 1'b0;
			flag_z       <= 1'b0;
			flag_c       <= 1'b0;
			state        <= ST_VEC;
			step         <= 3'd0;
			one_byte     <= 1'b0;
			vec_addr     <= `VEC_RESET;
			OP_ADDR      <= 16'h0000;
			BRANCH_TAKEN <= 1'b0;
			IRQ_ACK      <= 1'b0;
			IRQ_ACK_ID   <= {IRQ_ID_W{1'b0}};
			MEM_ADDR     <= 16'h0000;
			MEM_RE       <= 1'b0;
			MEM_WE       <= 1'b0;
			MEM_WDATA    <= 8'h00;
		end else begin
			MEM_RE  <= 1'b0;
			MEM_WE  <= 1'b0;
			IRQ_ACK <= 1'b0;
			case (state)
				ST_VEC: begin
					// Vector fetch, high byte first
					case (step)
						3'd0: begin
							MEM_ADDR <= vec_addr;
							MEM_RE   <= 1'b1;
							step     <= 3'd1;
						end
						3'd1: begin
							ip[15:8] <= MEM_RDATA;
							MEM_ADDR <= vec_addr + 16'h0001;
							MEM_RE   <= 1'b1;
							step     <= 3'd2;
						end
						default: begin
							ip[7:0] <= MEM_RDATA;
							state   <= ST_RUN;
							step    <= 3'd0;
						end
					endcase
				end
				ST_PUSH: begin
					if (step < stack_count) begin
						MEM_ADDR <= sp;
						MEM_WE   <= 1'b1;
						sp       <= sp - 16'h0001;
						step     <= step + 3'd1;
						if (one_byte)
							MEM_WDATA <= idx_hi;
						else begin
							case (step)
								3'd0:    MEM_WDATA <= ip[7:0];
								3'd1:    MEM_WDATA <= ip[15:8];
								3'd2:    MEM_WDATA <= idx_lo;
								3'd3:    MEM_WDATA <= acc;
								default: MEM_WDATA <= flags_byte;
							endcase
						end
					end else if (one_byte) begin
						state <= ST_RUN;
						step  <= 3'd0;
					end else begin
						// Mask rises only after the stacking, before the vector read
						flag_i <= 1'b1;
						state  <= ST_VEC;
						step   <= 3'd0;
					end
				end
				ST_PULL: begin
					if (step != 3'd0) begin
						if (one_byte)
							idx_hi <= MEM_RDATA;
						else begin
							case (step)
								3'd1: begin
									flag_v <= MEM_RDATA[`FLG_V];
									flag_h <= MEM_RDATA[`FLG_H];
									flag_i <= MEM_RDATA[`FLG_I];
									flag_n <= MEM_RDATA[`FLG_N];
									flag_z <= MEM_RDATA[`FLG_Z];
									flag_c <= MEM_RDATA[`FLG_C];
								end
								3'd2:    acc       <= MEM_RDATA;
								3'd3:    idx_lo    <= MEM_RDATA;
								3'd4:    ip[15:8]  <= MEM_RDATA;
								default: ip[7:0]   <= MEM_RDATA;
							endcase
						end
					end
					if (step < stack_count) begin
						sp       <= sp + 16'h0001;
						MEM_ADDR <= sp + 16'h0001;
						MEM_RE   <= 1'b1;
						step     <= step + 3'd1;
					end else begin
						state <= ST_RUN;
						step  <= 3'd0;
					end
				end
				default: begin
					if (irq_start) begin
						state      <= ST_PUSH;
						one_byte   <= 1'b0;
						step       <= 3'd0;
						vec_addr   <= irq_vec;
						IRQ_ACK    <= 1'b1;
						IRQ_ACK_ID <= irq_id;
					end else if (op_go) begin
						case (OP_CODE)
							`OP_ALU: begin
								acc    <= alu_result;
								flag_n <= alu_n;
								flag_z <= alu_z;
								if (upd_v)
									flag_v <= alu_v;
								if (upd_h)
									flag_h <= alu_h;
								if (upd_c)
									flag_c <= alu_c;
							end
							`OP_LDX: begin
								idx_hi <= OP_WIDE[15:8];
								idx_lo <= OP_WIDE[7:0];
							end
							`OP_FETCH: ip <= ip + 16'h0001;
							`OP_JUMP:  ip <= OP_WIDE;
							`OP_RSP:   sp[7:0] <= `SP_LOW_RESET;
							`OP_CLI:   flag_i <= 1'b0;
							`OP_SEI:   flag_i <= 1'b1;
							`OP_LDSP:  sp <= OP_WIDE;
							`OP_PUSH_INDEX_HIGH_OP: begin
								state    <= ST_PUSH;
								one_byte <= 1'b1;
								step     <= 3'd0;
							end
							`OP_PULL_INDEX_HIGH_OP: begin
								state    <= ST_PULL;
								one_byte <= 1'b1;
								step     <= 3'd0;
							end
							`OP_RTI: begin
								state    <= ST_PULL;
								one_byte <= 1'b0;
								step     <= 3'd0;
							end
							`OP_ADDR: begin
								if (OP_SEL[0])
									OP_ADDR <= addr_base + OP_WIDE;
								else
									OP_ADDR <= addr_base + {8'h00, OP_DATA};
							end
							`OP_BRANCH: begin
								case (OP_SEL[1:0])
									`BR_GT:  BRANCH_TAKEN <= !(flag_z | signed_lt);
									`BR_GE:  BRANCH_TAKEN <= !signed_lt;
									`BR_LE:  BRANCH_TAKEN <= flag_z | signed_lt;
									default: BRANCH_TAKEN <= signed_lt;
								endcase
							end
							default: ;
						endcase
					end else if (wr_commit) begin
						// Software writes never touch the mask
						case (wr_addr)
							`OFS_ACC: begin
								if (wr_strb[0])
									acc <= wr_data[7:0];
							end
							`OFS_INDEX: {idx_hi, idx_lo} <= merge16({idx_hi, idx_lo}, wr_data[15:0], wr_strb[1:0]);
							`OFS_STACK: sp <= merge16(sp, wr_data[15:0], wr_strb[1:0]);
							`OFS_IP:    ip <= merge16(ip, wr_data[15:0], wr_strb[1:0]);
							`OFS_FLAGS: begin
								if (wr_strb[0]) begin
									flag_v <= wr_data[`FLG_V];
									flag_h <= wr_data[`FLG_H];
									flag_n <= wr_data[`FLG_N];
									flag_z <= wr_data[`FLG_Z];
									flag_c <= wr_data[`FLG_C];
								end
							end
							default: ;
						endcase
					end
				end
			endcase
		end
	end

	// Register bus channels
	always @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			wr_addr <= 8'h00;
			wr_data <= 32'h00000000;
			wr_strb <= 4'h0;
			BVALID  <= 1'b0;
			BRESP   <= `RESP_OKAY;
			RVALID  <= 1'b0;
			RDATA   <= 32'h00000000;
			RRESP   <= `RESP_OKAY;
		end else begin
			if (AWVALID && !aw_held) begin
				aw_held <= 1'b1;
				wr_addr <= {AWADDR[7:2], 2'b00};
			end
			if (WVALID && !w_held) begin
				w_held  <= 1'b1;
				wr_data <= WDATA;
				wr_strb <= WSTRB;
			end
			if (wr_commit) begin
				aw_held <= 1'b0;
				w_held  <= 1'b0;
				BVALID  <= 1'b1;
				BRESP   <= mapped(wr_addr) ? `RESP_OKAY : `RESP_DECERR;
			end else if (BVALID && BREADY)
				BVALID <= 1'b0;
			if (ARVALID && !RVALID) begin
				RVALID <= 1'b1;
				RRESP  <= mapped({ARADDR[7:2], 2'b00}) ? `RESP_OKAY : `RESP_DECERR;
				case ({ARADDR[7:2], 2'b00})
					`OFS_ACC:    RDATA <= {24'h000000, acc};
					`OFS_INDEX:  RDATA <= {16'h0000, idx_hi, idx_lo};
					`OFS_STACK:  RDATA <= {16'h0000, sp};
					`OFS_IP:     RDATA <= {16'h0000, ip};
					`OFS_FLAGS:  RDATA <= {24'h000000, flags_byte};
					`OFS_STATUS: RDATA <= {{(24-IRQ_LINES){1'b0}}, IRQ_REQ, 5'h00, state, BUSY};
					default:     RDATA <= 32'h00000000;
				endcase
			end else if (RVALID && RREADY)
				RVALID <= 1'b0;
		end
	end
endmodule

//--- mem_model.sv
// Purpose: Byte memory standing on the far side of the register set
// Assumes: Read data is combinational while re is high, writes land at the clock edge
// Notes:   An unselected read port shows the inverse of the last value read
`timescale 1ns/1ps
module mem_model (
	// Bus
	input  wire        clk,
	input  wire [15:0] addr,
	input  wire        re,
	input  wire        we,
	input  wire [7:0]  wdata,
	output wire [7:0]  rdata
);
	reg [7:0] data [0:65535];
	reg [7:0] last;
	assign rdata = re ? data[addr] : ~last;
	always @(posedge clk) begin
		if (we)
			data[addr] <= wdata;
		if (re)
			last <= data[addr];
	end
	// Reset vector and the vector of request line 1
	initial begin
		last = 8'h00;
		data[16'hfffe] = 8'h12;
		data[16'hffff] = 8'h34;
		data[16'hfffa] = 8'h20;
		data[16'hfffb] = 8'h00;
	end
endmodule

//--- cpu_register_set_flags_properties.sv
// Purpose: Timing relations of the register set seen at its ports
// Assumes: Bound to the register set, one clock domain
// Notes:   Interrupt entry timing follows the hand-over walk
`timescale 1ns/1ps
`include "cpu_core_regs.vh"
module cpu_register_set_flags_properties #(
	parameter IRQ_LINES = 4,
	parameter IRQ_ID_W  = 2
) (
	// Clock and reset
	input wire                 CLOCK,
	input wire                 RSTN,
	// Sequencer
	input wire                 OP_VALID,
	input wire                 OP_READY,
	input wire [3:0]           OP_CODE,
	input wire [2:0]           OP_SEL,
	input wire [7:0]           OP_DATA,
	input wire                 BUSY,
	input wire [7:0]           FLAGS,
	// Interrupts
	input wire [IRQ_LINES-1:0] IRQ_REQ,
	input wire                 BOUNDARY,
	input wire                 IRQ_ACK,
	input wire [IRQ_ID_W-1:0]  IRQ_ACK_ID,
	// Memory
	input wire [15:0]          MEM_ADDR,
	input wire                 MEM_RE,
	input wire                 MEM_WE
);
	reg  [IRQ_ID_W-1:0] low_id;
	integer             k;
	wire                take = OP_VALID && OP_READY;
	always @* begin
		low_id = {IRQ_ID_W{1'b0}};
		for (k = IRQ_LINES - 1; k >= 0; k = k - 1)
			if (IRQ_REQ[k])
				low_id = k[IRQ_ID_W-1:0];
	end
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RSTN);
	property p_flag_ones; FLAGS[6:5] == 2'b11; endproperty
	a_flag_ones: assert property (p_flag_ones) else $error("fixed flag bits not one");
	property p_vector; $rose(RSTN) |=> (MEM_RE && MEM_ADDR == 16'hfffe) ##1 (MEM_RE && MEM_ADDR == 16'hffff); endproperty
	a_vector: assert property (p_vector) else $error("reset vector not fetched");
	property p_mask_reset; $rose(RSTN) |-> FLAGS[`FLG_I] [*3]; endproperty
	a_mask_reset: assert property (p_mask_reset) else $error("mask not set after reset");
	property p_mask_clear; $fell(FLAGS[`FLG_I]) |-> $past(take && OP_CODE == `OP_CLI) || $past(BUSY); endproperty
	a_mask_clear: assert property (p_mask_clear) else $error("mask cleared without cause");
	property p_mask_block; IRQ_ACK |-> $past(BOUNDARY && !FLAGS[`FLG_I] && IRQ_REQ != 0); endproperty
	a_mask_block: assert property (p_mask_block) else $error("interrupt taken while masked");
	property p_priority; IRQ_ACK |-> IRQ_ACK_ID == $past(low_id); endproperty
	a_priority: assert property (p_priority) else $error("wrong interrupt chosen");
	sequence s_stack; (MEM_WE && !FLAGS[`FLG_I]) [*5]; endsequence
	property p_entry; IRQ_ACK |=> s_stack ##1 (FLAGS[`FLG_I] && !MEM_RE) ##1 MEM_RE; endproperty
	a_entry: assert property (p_entry) else $error("interrupt entry out of order");
	property p_push_dec; MEM_WE && $past(MEM_WE) |-> MEM_ADDR == $past(MEM_ADDR) - 16'h0001; endproperty
	a_push_dec: assert property (p_push_dec) else $error("stack push not decrementing");
	property p_load_nz;
		take && OP_CODE == `OP_ALU && OP_SEL == `ALU_LOAD |=>
			FLAGS[`FLG_N] == $past(OP_DATA[7]) && FLAGS[`FLG_Z] == ($past(OP_DATA) == 8'h00);
	endproperty
	a_load_nz: assert property (p_load_nz) else $error("load flags wrong");
	c_irq: cover property (IRQ_ACK);
	c_cli: cover property (take && OP_CODE == `OP_CLI);
	c_rti: cover property (take && OP_CODE == `OP_RTI);
endmodule

//--- cpu_register_set_flags_tb.sv
// Purpose: Self-checking bench for the CPU register set and flag logic
// Assumes: AXI4-Lite master tasks, sequencer op task, memory model on the far side
// Notes:   Expected values are worked out by hand from the register behaviour
`timescale 1ns/1ps
`include "cpu_core_regs.vh"
module cpu_register_set_flags_tb;
	reg         CLOCK = 0, RSTN = 0, AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
	reg  [7:0]  AWADDR = 0, ARADDR = 0, OP_DATA = 0;
	reg  [31:0] WDATA = 0, rd;
	reg         OP_VALID = 0, BOUNDARY = 1;
	reg  [3:0]  OP_CODE = 0, IRQ_REQ = 0;
	reg  [2:0]  OP_SEL = 0;
	reg  [15:0] OP_WIDE = 0;
	reg  [1:0]  rsp;
	reg  [55:0] alu [0:8];
	wire        AWREADY, WREADY, BVALID, ARREADY, RVALID, OP_READY, BRANCH_TAKEN, BUSY, IRQ_ACK, MEM_RE, MEM_WE;
	wire [1:0]  BRESP, RRESP, IRQ_ACK_ID;
	wire [31:0] RDATA;
	wire [15:0] OP_ADDR, MEM_ADDR;
	wire [7:0]  FLAGS, MEM_WDATA, MEM_RDATA;
	integer     n_errors = 0, n_tests = 0, cycles = 0, n_ack = 0, i;
	cpu_register_set_flags #(.IRQ_LINES(4), .IRQ_ID_W(2)) uut (.CLOCK(CLOCK), .RSTN(RSTN),
		.AWVALID(AWVALID), .AWREADY(AWREADY), .AWADDR(AWADDR), .WVALID(WVALID), .WREADY(WREADY),
		.WDATA(WDATA), .WSTRB(4'hf), .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP), .ARVALID(ARVALID),
		.ARREADY(ARREADY), .ARADDR(ARADDR), .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA), .RRESP(RRESP),
		.OP_VALID(OP_VALID), .OP_READY(OP_READY), .OP_CODE(OP_CODE), .OP_SEL(OP_SEL), .OP_DATA(OP_DATA),
		.OP_WIDE(OP_WIDE), .OP_ADDR(OP_ADDR), .BRANCH_TAKEN(BRANCH_TAKEN), .BUSY(BUSY), .FLAGS(FLAGS),
		.IRQ_REQ(IRQ_REQ), .BOUNDARY(BOUNDARY), .IRQ_ACK(IRQ_ACK), .IRQ_ACK_ID(IRQ_ACK_ID), .MEM_ADDR(MEM_ADDR),
		.MEM_RE(MEM_RE), .MEM_WE(MEM_WE), .MEM_WDATA(MEM_WDATA), .MEM_RDATA(MEM_RDATA));
	mem_model mem (.clk(CLOCK), .addr(MEM_ADDR), .re(MEM_RE), .we(MEM_WE), .wdata(MEM_WDATA), .rdata(MEM_RDATA));
	always #25 CLOCK = ~CLOCK;
	always @(posedge CLOCK) begin
		cycles <= cycles + 1;
		if (IRQ_ACK === 1'b1)
			n_ack <= n_ack + 1;
		if (cycles == 5000) begin
			n_errors = n_errors + 1;
			summarize;
		end
	end
	task check(input [31:0] seen, input [31:0] exp);
		begin
			n_tests = n_tests + 1;
			if (seen !== exp) begin
				n_errors = n_errors + 1;
				$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task wr(input [7:0] a, input [31:0] d);
		integer t;
		begin
			AWADDR <= a;
			WDATA <= d;
			AWVALID <= 1'b1;
			WVALID <= 1'b1;
			BREADY <= 1'b1;
			for (t = 0; t < 200 && (t == 0 || AWVALID || WVALID || BREADY); t = t + 1) begin
				@(posedge CLOCK);
				if (AWVALID && AWREADY)
					AWVALID <= 1'b0;
				if (WVALID && WREADY)
					WVALID <= 1'b0;
				if (BREADY && BVALID) begin
					BREADY <= 1'b0;
					rsp = BRESP;
				end
			end
			if (t == 200)
				n_errors = n_errors + 1;
		end
	endtask
	task rdchk(input [7:0] a, input [31:0] exp);
		integer t;
		begin
			rd = ~exp;
			ARADDR <= a;
			ARVALID <= 1'b1;
			RREADY <= 1'b1;
			for (t = 0; t < 200 && (t == 0 || RREADY); t = t + 1) begin
				@(posedge CLOCK);
				if (ARVALID && ARREADY)
					ARVALID <= 1'b0;
				if (RREADY && RVALID) begin
					RREADY <= 1'b0;
					rd = RDATA;
					rsp = RRESP;
				end
			end
			if (t == 200)
				n_errors = n_errors + 1;
			check(rd, exp);
		end
	endtask
	// Offers one op, holds it until taken, then waits out any sequence it starts
	task op(input [3:0] c, input [2:0] s, input [7:0] d, input [15:0] w);
		integer t;
		begin
			OP_VALID <= 1'b1;
			OP_CODE <= c;
			OP_SEL <= s;
			OP_DATA <= d;
			OP_WIDE <= w;
			for (t = 0; t < 200 && (t == 0 || OP_VALID); t = t + 1) begin
				@(posedge CLOCK);
				if (OP_VALID && OP_READY)
					OP_VALID <= 1'b0;
			end
			if (t == 200)
				n_errors = n_errors + 1;
			for (t = 0; t < 200 && BUSY !== 1'b0; t = t + 1)
				@(posedge CLOCK);
			if (t == 200)
				n_errors = n_errors + 1;
			@(posedge CLOCK);
		end
	endtask
	task summarize;
		begin
			$display("comparisons %0d mismatches %0d", n_tests, n_errors);
			if (n_errors == 0 && n_tests > 0)
				$display("All tests passed");
			else
				$display("Some tests failed");
			$finish;
		end
	endtask
	initial begin
		// Preset flags, A, sub-op, operand, expected A, expected flags, compare mask
		alu[0] = 56'h00_08_00_08_10_78_ff;
		alu[1] = 56'h00_7f_00_01_80_fc_ff;
		alu[2] = 56'h00_ff_00_01_00_7b_ff;
		alu[3] = 56'h01_01_01_01_03_68_ff;
		alu[4] = 56'h00_00_02_01_ff_6d_ef;
		alu[5] = 56'h80_f0_04_0f_00_6a_ff;
		alu[6] = 56'h00_00_05_80_80_6c_ff;
		alu[7] = 56'h00_81_06_81_02_e9_ff;
		alu[8] = 56'h10_00_07_00_06_68_0f;
		repeat (10) @(posedge CLOCK);
		check(FLAGS, 32'h68);
		RSTN <= 1'b1;
		repeat (4) @(posedge CLOCK);
		rdchk(`OFS_IP, 32'h1234);
		rdchk(`OFS_STACK, 32'h00ff);
		rdchk(8'h18, 32'h0);
		check(rsp, `RESP_DECERR);
		wr(8'h18, 32'h1);
		check(rsp, `RESP_DECERR);
		wr(`OFS_FLAGS, 32'h00);
		check(rsp, `RESP_OKAY);
		rdchk(`OFS_FLAGS, 32'h68);
		$display("end of reset and register test");
		for (i = 0; i < 9; i = i + 1) begin
			wr(`OFS_FLAGS, alu[i][55:48]);
			wr(`OFS_ACC, alu[i][47:40]);
			op(`OP_ALU, alu[i][34:32], alu[i][31:24], 16'h0000);
			check(FLAGS & alu[i][7:0], alu[i][15:8] & alu[i][7:0]);
			rdchk(`OFS_ACC, alu[i][23:16]);
		end
		wr(`OFS_FLAGS, 32'h80);
		for (i = 0; i < 4; i = i + 1) begin
			op(`OP_BRANCH, i[2:0], 8'h00, 16'h0000);
			check(BRANCH_TAKEN, i > 1);
		end
		$display("end of flag test");
		op(`OP_LDSP, 3'h0, 8'h00, 16'h1234);
		op(`OP_RSP, 3'h0, 8'h00, 16'h0000);
		rdchk(`OFS_STACK, 32'h12ff);
		op(`OP_ADDR, 3'h0, 8'h10, 16'h0000);
		check(OP_ADDR, 16'h130f);
		op(`OP_ADDR, 3'h1, 8'h00, 16'h0100);
		check(OP_ADDR, 16'h13ff);
		wr(`OFS_INDEX, 32'hbeef);
		rdchk(`OFS_INDEX, 32'hbeef);
		op(`OP_PUSH_INDEX_HIGH_OP, 3'h0, 8'h00, 16'h0000);
		check(mem.data[16'h12ff], 8'hbe);
		rdchk(`OFS_STACK, 32'h12fe);
		wr(`OFS_INDEX, 32'h11ef);
		op(`OP_PULL_INDEX_HIGH_OP, 3'h0, 8'h00, 16'h0000);
		rdchk(`OFS_INDEX, 32'hbeef);
		rdchk(`OFS_STACK, 32'h12ff);
		$display("end of stack test");
		wr(`OFS_IP, 32'h4000);
		wr(`OFS_ACC, 32'h5a);
		op(`OP_CLI, 3'h0, 8'h00, 16'h0000);
		check(FLAGS[`FLG_I], 1'b0);
		IRQ_REQ <= 4'b0110;
		for (i = 0; i < 100 && BUSY !== 1'b1; i = i + 1)
			@(posedge CLOCK);
		for (i = 0; i < 100 && BUSY !== 1'b0; i = i + 1)
			@(posedge CLOCK);
		repeat (6) @(posedge CLOCK);
		check(n_ack, 1);
		IRQ_REQ <= 4'b0000;
		rdchk(`OFS_IP, 32'h2000);
		check(FLAGS[`FLG_I], 1'b1);
		rdchk(`OFS_STACK, 32'h12fa);
		check(mem.data[16'h12fe], 8'h40);
		check(mem.data[16'h12fd], 8'hef);
		wr(`OFS_ACC, 32'h00);
		op(`OP_RTI, 3'h0, 8'h00, 16'h0000);
		rdchk(`OFS_ACC, 32'h5a);
		rdchk(`OFS_IP, 32'h4000);
		check(FLAGS[`FLG_I], 1'b0);
		op(`OP_FETCH, 3'h0, 8'h00, 16'h0000);
		rdchk(`OFS_IP, 32'h4001);
		op(`OP_JUMP, 3'h0, 8'h00, 16'h3000);
		rdchk(`OFS_IP, 32'h3000);
		$display("end of interrupt test");
		summarize;
	end
endmodule
bind cpu_register_set_flags cpu_register_set_flags_properties #(.IRQ_LINES(IRQ_LINES), .IRQ_ID_W(IRQ_ID_W)) chk (
	.CLOCK(CLOCK), .RSTN(RSTN), .OP_VALID(OP_VALID), .OP_READY(OP_READY), .OP_CODE(OP_CODE), .OP_SEL(OP_SEL),
	.OP_DATA(OP_DATA), .BUSY(BUSY), .FLAGS(FLAGS), .IRQ_REQ(IRQ_REQ), .BOUNDARY(BOUNDARY), .IRQ_ACK(IRQ_ACK),
	.IRQ_ACK_ID(IRQ_ACK_ID), .MEM_ADDR(MEM_ADDR), .MEM_RE(MEM_RE), .MEM_WE(MEM_WE));
